// ### design/gpio_freqcount_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register pointer on the serial control port
// Notes:   definitions only
`ifndef GPIO_FREQCOUNT_DEFS_SVH
`define GPIO_FREQCOUNT_DEFS_SVH

`define REG_SCRATCH        8'h19
`define REG_PINCFG         8'h1a
`define REG_FREQ           8'h1b
`define REG_STATUS         8'h1c

`define SCRATCH_RST        8'h01
`define PINCFG_RST         8'h00
`define FREQ_RST           8'h00
`define PINCFG_WMASK       8'hbb

`define PINCFG_GLB_LVL     7
`define PINCFG_GLB_DIR     5
`define PINCFG_GLB_EN      4
`define PINCFG_P9_LVL      3
`define PINCFG_P9_DIR      1
`define PINCFG_P9_EN       0

`define STS_TX_DUAL        5
`define STS_RX_DUAL        4
`define STS_AUD_LOCK       3
`define STS_SIG_DET        1
`define STS_LOCK           0

`define OSC_PERIOD_NS      50
`define CLK_PERIOD_NS      40
`define COUNT_MAX          8'hff

`define TARGET_ADDR        7'h2c

`endif

// ### design/gpio_freqcount_pkg.sv
// Purpose: shared types for the pin, status and frequency count block
// Assumes: constants live in gpio_freqcount_defs.svh
// Notes:   one-hot state codes are written out
package gpio_freqcount_pkg;

  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_ADDR    = 9'h002,
    ST_ACK_ADR = 9'h004,
    ST_PTR     = 9'h008,
    ST_ACK_PTR = 9'h010,
    ST_WR      = 9'h020,
    ST_ACK_WR  = 9'h040,
    ST_RD      = 9'h080,
    ST_RACK    = 9'h100
  } ctl_state_t;

  typedef struct packed {
    ctl_state_t st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic       rw;
    logic       sda_drv;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] scratch;
    logic [7:0] pincfg;
    logic       meas_start;
    logic [7:0] meas_interval;
    logic       pin9_lvl;
    logic       pin9_oe_n;
    logic [3:0] oth_lvl;
    logic [3:0] oth_oe_n;
  } top_state_t;

  typedef struct packed {
    logic       active;
    logic [7:0] remaining;
    logic [7:0] count;
    logic [7:0] result;
    logic [5:0] acc;
    logic       pix_q;
  } meas_state_t;

  // returns {oe_n, level} for a {dir, en} pair
  function automatic logic [1:0] pin_drive(input logic [1:0] mode,
                                           input logic       gpio_lvl,
                                           input logic       func_lvl);
    logic [1:0] r;
    r = 2'h2;
    case (mode)
      2'h0:    r = {1'b0, func_lvl};
      2'h1:    r = {1'b0, gpio_lvl};
      2'h2:    r = 2'h2;
      2'h3:    r = 2'h2;
      default: r = 2'h2;
    endcase
    return r;
  endfunction : pin_drive

endpackage : gpio_freqcount_pkg

// ### design/freq_meas_if.sv
// Purpose: carries a measurement request and its result
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/100ps
interface freq_meas_if;
  logic       start;
  logic [7:0] interval;
  logic [7:0] result;
  logic       busy;
  modport ctrl (output start, output interval, input result, input busy);
  modport meas (input start, input interval, output result, output busy);
endinterface : freq_meas_if

// ### design/pixel_freq_meter.sv
// Purpose: counts pixel clock rising edges over a gated interval
// Assumes: pixel clock below half of ref_clk, sampled directly
// Notes:   result changes at the end of an interval, or clears at once on a start with interval 0
`timescale 1ns/100ps
`include "gpio_freqcount_defs.svh"
module pixel_freq_meter (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // pixel clock sample
  input  wire logic pix_clk,
  // request side
  freq_meas_if.meas m
);
  localparam logic [5:0] OSC_NS = 6'(`OSC_PERIOD_NS);
  localparam logic [5:0] CLK_NS = 6'(`CLK_PERIOD_NS);

  gpio_freqcount_pkg::meas_state_t s_r, s_nxt;

  always_comb begin
    logic [6:0] acc_sum;
    logic       tick;
    acc_sum = 7'(s_r.acc) + 7'(CLK_NS);
    tick    = 1'b0;
    s_nxt   = s_r;
    s_nxt.pix_q = pix_clk;
    // fractional divider: average tick spacing equals one oscillator period
    if (acc_sum >= 7'(OSC_NS)) begin
      tick      = 1'b1;
      s_nxt.acc = 6'(acc_sum - 7'(OSC_NS));
    end else begin
      s_nxt.acc = acc_sum[5:0];
    end
    if (s_r.active) begin
      if (pix_clk && !s_r.pix_q && s_r.count != `COUNT_MAX) begin
        s_nxt.count = s_r.count + 8'h01;
      end
      if (tick) begin
        s_nxt.remaining = s_r.remaining - 8'h01;
        if (s_r.remaining == 8'h01) begin
          s_nxt.active = 1'b0;
          s_nxt.result = s_nxt.count;
        end
      end
    end
    if (m.start) begin
      s_nxt.count     = 8'h00;
      s_nxt.remaining = m.interval;
      s_nxt.active    = (m.interval != 8'h00);
      s_nxt.acc       = 6'h00;
      if (m.interval == 8'h00) begin
        s_nxt.result = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{active: 1'b0, remaining: 8'h00, count: 8'h00,
               result: `FREQ_RST, acc: 6'h00, pix_q: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign m.result = s_r.result;
  assign m.busy   = s_r.active;
endmodule : pixel_freq_meter

// ### design/gpio_freqcount_status_regs.sv
// Purpose: scratch, pin configuration, frequency count and link status registers
// Assumes: control port is a two-wire serial target, inputs synchronous to ref_clk
// Notes:   pins 0..3 take the global pair only when their own config is idle
`timescale 1ns/100ps
`include "gpio_freqcount_defs.svh"

// Notes on behaviour
// - 0x19 is a free read/write byte, reset 0x01, no side effects.
// - global level bit 7 drives non-GPIO pins when global pair forces output.
// - global {dir,en}: 00 functional, 10 tri-state, 01 forced out, 11 forced in.
// - a pin's own {dir,en} pair wins over the global pair.
// - pin 9 outputs its level bit when GPIO, output, remote control off.
// - pin 9 {dir,en}: 00 follows the global pair, 10 tri-state, 01 GPIO out, 11 GPIO in with remote control off.
// - each write to 0x1b starts a new pixel clock edge count.
// - interval is written value times the 50 ns oscillator period.
// - reading 0x1b returns the count of the last interval, not the write.
// - count saturates at 0xff instead of wrapping.
// - status bit 5 shows transmit dual-link mode.
// - status bit 4 shows receive dual-link mode.
// - status bit 3 shows audio clock PLL locked.
// - status bit 1 shows serial input signal detected.
// - status bit 0 shows lock; in dual-link both channels must lock.
module gpio_freqcount_status_regs #(
  parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR  // arbitrary value
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // serial control port
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // pixel clock sample
  input  wire logic       pix_clk,
  // link status sources
  input  wire logic       transmit_two_link_flag,
  input  wire logic       receive_two_link_flag,
  input  wire logic       audio_pll_locked,
  input  wire logic       serial_signal_detect,
  input  wire logic       rx_lock_ch0,
  input  wire logic       rx_lock_ch1,
  // pin 9
  input  wire logic       pin_nine_remote_en,
  input  wire logic       pin_nine_remote_level,
  input  wire logic       pin_nine_func_level,
  output logic            pin_nine_level,
  output logic            pin_nine_oe_n,
  // pins 0..3 under global control
  input  wire logic [3:0] other_pin_own_active,
  input  wire logic [3:0] other_pin_func_level,
  output logic      [3:0] other_pin_level,
  output logic      [3:0] other_pin_oe_n
);

  gpio_freqcount_pkg::top_state_t s_r, s_nxt;
  freq_meas_if fm ();

  pixel_freq_meter u_meter (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pix_clk (pix_clk),
    .m       (fm.meas)
  );

  // register read view
  logic [7:0] status_byte;
  logic       lock_bit;

  always_comb begin
    // dual-link lock needs both channels
    lock_bit = receive_two_link_flag ? (rx_lock_ch0 && rx_lock_ch1)
                                     : rx_lock_ch0;
    status_byte = 8'h00;
    status_byte[`STS_TX_DUAL]  = transmit_two_link_flag;
    status_byte[`STS_RX_DUAL]  = receive_two_link_flag;
    status_byte[`STS_AUD_LOCK] = audio_pll_locked;
    status_byte[`STS_SIG_DET]  = serial_signal_detect;
    status_byte[`STS_LOCK]     = lock_bit;
  end

  function automatic logic [7:0] reg_read(input logic [7:0] a,
                                          input logic [7:0] scr,
                                          input logic [7:0] cfg,
                                          input logic [7:0] cnt,
                                          input logic [7:0] sts);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `REG_SCRATCH: d = scr;
      `REG_PINCFG:  d = cfg & `PINCFG_WMASK;
      `REG_FREQ:    d = cnt;
      `REG_STATUS:  d = sts;
      default:      d = 8'h00;
    endcase
    return d;
  endfunction : reg_read

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise   = scl && !s_r.scl_q;
  assign scl_fall   = !scl && s_r.scl_q;
  assign start_cond = scl && s_r.scl_q && s_r.sda_q && !sda_i;
  assign stop_cond  = scl && s_r.scl_q && !s_r.sda_q && sda_i;

  always_comb begin
    logic [7:0] rd;
    logic [1:0] glb_mode;
    logic [1:0] p9_mode;
    logic [1:0] drv;
    logic       p9_gpio_lvl;
    rd          = 8'h00;
    glb_mode    = 2'h0;
    p9_mode     = 2'h0;
    drv         = 2'h2;
    p9_gpio_lvl = 1'b0;
    s_nxt       = s_r;
    s_nxt.scl_q      = scl;
    s_nxt.sda_q      = sda_i;
    s_nxt.meas_start = 1'b0;

    // serial control target
    if (start_cond) begin
      s_nxt.st      = gpio_freqcount_pkg::ST_ADDR;
      s_nxt.cnt     = 4'h0;
      s_nxt.sda_drv = 1'b0;
    end else if (stop_cond) begin
      s_nxt.st      = gpio_freqcount_pkg::ST_IDLE;
      s_nxt.sda_drv = 1'b0;
    end else if (scl_rise) begin
      case (s_r.st)
        gpio_freqcount_pkg::ST_ADDR,
        gpio_freqcount_pkg::ST_PTR,
        gpio_freqcount_pkg::ST_WR: begin
          s_nxt.sh  = {s_r.sh[6:0], sda_i};
          s_nxt.cnt = s_r.cnt + 4'h1;
        end
        gpio_freqcount_pkg::ST_RD: begin
          s_nxt.cnt = s_r.cnt + 4'h1;
        end
        gpio_freqcount_pkg::ST_RACK: begin
          // controller not acknowledging ends the read burst
          s_nxt.rw = !sda_i;
        end
        default: begin
          s_nxt.cnt = s_r.cnt;
        end
      endcase
    end else if (scl_fall) begin
      case (s_r.st)
        gpio_freqcount_pkg::ST_ADDR: begin
          if (s_r.cnt == 4'h8) begin
            if (s_r.sh[7:1] == TARGET_ADDR) begin
              s_nxt.st      = gpio_freqcount_pkg::ST_ACK_ADR;
              s_nxt.rw      = s_r.sh[0];
              s_nxt.sda_drv = 1'b1;
            end else begin
              s_nxt.st = gpio_freqcount_pkg::ST_IDLE;
            end
          end
        end
        gpio_freqcount_pkg::ST_ACK_ADR,
        gpio_freqcount_pkg::ST_RACK: begin
          if (s_r.st == gpio_freqcount_pkg::ST_ACK_ADR && !s_r.rw) begin
            s_nxt.st      = gpio_freqcount_pkg::ST_PTR;
            s_nxt.cnt     = 4'h0;
            s_nxt.sda_drv = 1'b0;
          end else if (s_r.st == gpio_freqcount_pkg::ST_RACK && !s_r.rw) begin
            s_nxt.st      = gpio_freqcount_pkg::ST_IDLE;
            s_nxt.sda_drv = 1'b0;
          end else begin
            // whole byte taken at once, so a count update never splits it
            rd = reg_read(s_r.ptr, s_r.scratch, s_r.pincfg, fm.result,
                          status_byte);
            s_nxt.sh      = {rd[6:0], 1'b0};
            s_nxt.sda_drv = !rd[7];
            s_nxt.ptr     = s_r.ptr + 8'h01;
            s_nxt.cnt     = 4'h0;
            s_nxt.st      = gpio_freqcount_pkg::ST_RD;
          end
        end
        gpio_freqcount_pkg::ST_PTR: begin
          if (s_r.cnt == 4'h8) begin
            s_nxt.ptr     = s_r.sh;
            s_nxt.sda_drv = 1'b1;
            s_nxt.st      = gpio_freqcount_pkg::ST_ACK_PTR;
          end
        end
        gpio_freqcount_pkg::ST_ACK_PTR,
        gpio_freqcount_pkg::ST_ACK_WR: begin
          s_nxt.sda_drv = 1'b0;
          s_nxt.cnt     = 4'h0;
          s_nxt.st      = gpio_freqcount_pkg::ST_WR;
        end
        gpio_freqcount_pkg::ST_WR: begin
          if (s_r.cnt == 4'h8) begin
            case (s_r.ptr)
              `REG_SCRATCH: s_nxt.scratch = s_r.sh;
              `REG_PINCFG:  s_nxt.pincfg  = s_r.sh & `PINCFG_WMASK;
              `REG_FREQ: begin
                s_nxt.meas_start    = 1'b1;
                s_nxt.meas_interval = s_r.sh;
              end
              default: s_nxt.meas_start = 1'b0;
            endcase
            s_nxt.ptr     = s_r.ptr + 8'h01;
            s_nxt.sda_drv = 1'b1;
            s_nxt.st      = gpio_freqcount_pkg::ST_ACK_WR;
          end
        end
        gpio_freqcount_pkg::ST_RD: begin
          if (s_r.cnt == 4'h8) begin
            s_nxt.sda_drv = 1'b0;
            s_nxt.st      = gpio_freqcount_pkg::ST_RACK;
          end else begin
            s_nxt.sda_drv = !s_r.sh[7];
            s_nxt.sh      = {s_r.sh[6:0], 1'b0};
          end
        end
        default: begin
          s_nxt.sda_drv = 1'b0;
        end
      endcase
    end

    // pin drive
    glb_mode = {s_r.pincfg[`PINCFG_GLB_DIR], s_r.pincfg[`PINCFG_GLB_EN]};
    p9_mode  = {s_r.pincfg[`PINCFG_P9_DIR], s_r.pincfg[`PINCFG_P9_EN]};
    // with the pin 9 enable bit set, remote control makes the pin an output carrying the far value
    p9_gpio_lvl = pin_nine_remote_en ? pin_nine_remote_level
                                     : s_r.pincfg[`PINCFG_P9_LVL];
    if (p9_mode != 2'h0) begin
      if (s_r.pincfg[`PINCFG_P9_EN] && pin_nine_remote_en) begin
        drv = {1'b0, pin_nine_remote_level};
      end else begin
        drv = gpio_freqcount_pkg::pin_drive(p9_mode, p9_gpio_lvl,
                                            pin_nine_func_level);
      end
    end else begin
      drv = gpio_freqcount_pkg::pin_drive(glb_mode, s_r.pincfg[`PINCFG_GLB_LVL],
                                          pin_nine_func_level);
    end
    s_nxt.pin9_oe_n = drv[1];
    s_nxt.pin9_lvl  = drv[0];
    for (int i = 0; i < 4; i++) begin
      if (other_pin_own_active[i]) begin
        // own config wins; pin logic outside takes over
        drv = 2'h2;
      end else begin
        drv = gpio_freqcount_pkg::pin_drive(glb_mode, s_r.pincfg[`PINCFG_GLB_LVL],
                                            other_pin_func_level[i]);
      end
      s_nxt.oth_oe_n[i] = drv[1];
      s_nxt.oth_lvl[i]  = drv[0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{st: gpio_freqcount_pkg::ST_IDLE, sh: 8'h00, cnt: 4'h0,
               ptr: 8'h00, rw: 1'b0, sda_drv: 1'b0, scl_q: 1'b1, sda_q: 1'b1,
               scratch: `SCRATCH_RST, pincfg: `PINCFG_RST, meas_start: 1'b0,
               meas_interval: 8'h00, pin9_lvl: 1'b0, pin9_oe_n: 1'b1,
               oth_lvl: 4'h0, oth_oe_n: 4'hf};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fm.start    = s_r.meas_start;
  assign fm.interval = s_r.meas_interval;

  // open drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_n = !s_r.sda_drv;

  assign pin_nine_level  = s_r.pin9_lvl;
  assign pin_nine_oe_n   = s_r.pin9_oe_n;
  assign other_pin_level = s_r.oth_lvl;
  assign other_pin_oe_n  = s_r.oth_oe_n;
endmodule : gpio_freqcount_status_regs

// ### bench/gpio_freqcount_status_regs_assertions.sv
// Purpose: temporal checks on the serial port and pin outputs
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to the block's top module
`timescale 1ns/100ps
module gpio_freqcount_checker (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // serial port
  input wire logic       scl,
  input wire logic       sda_o,
  input wire logic       sda_oe_n,
  // pin 9
  input wire logic       pin_nine_func_level,
  input wire logic       pin_nine_level,
  input wire logic       pin_nine_oe_n,
  // pins 0..3
  input wire logic [3:0] other_pin_own_active,
  input wire logic [3:0] other_pin_func_level,
  input wire logic [3:0] other_pin_level,
  input wire logic [3:0] other_pin_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  property p_sda_open_drain;
    sda_o == 1'b0;
  endproperty
  // target may move sda only while scl is low, else it fakes start or stop
  property p_sda_stable;
    scl && $past(scl) && $past(scl, 2) |-> $stable(sda_oe_n);
  endproperty
  property p_ack_hold;
    $fell(sda_oe_n) |-> !sda_oe_n [*3];
  endproperty
  property p_own_release;
    (other_pin_oe_n & $past(other_pin_own_active)) == $past(other_pin_own_active);
  endproperty
  property p_reset_pin9;
    $rose(resetn) |=> !pin_nine_oe_n && pin_nine_level == $past(pin_nine_func_level);
  endproperty
  property p_reset_others;
    $rose(resetn) |=> other_pin_oe_n == $past(other_pin_own_active);
  endproperty
  property p_global_uniform;
    $past(other_pin_own_active) == 4'h0 |-> other_pin_oe_n inside {4'h0, 4'hf};
  endproperty
  property p_global_level;
    $past(other_pin_own_active) == 4'h0 && other_pin_oe_n == 4'h0 |->
      other_pin_level == $past(other_pin_func_level) || other_pin_level inside {4'h0, 4'hf};
  endproperty

  a_sda_open_drain: assert property (p_sda_open_drain) else $error("sda high");
  a_sda_stable: assert property (p_sda_stable) else $error("sda moved, scl high");
  a_ack_hold: assert property (p_ack_hold) else $error("sda low too short");
  a_own_release: assert property (p_own_release) else $error("own pin driven");
  a_reset_pin9: assert property (p_reset_pin9) else $error("pin 9 not functional");
  a_reset_others: assert property (p_reset_others) else $error("pins not functional");
  a_global_uniform: assert property (p_global_uniform) else $error("mixed enables");
  a_global_level: assert property (p_global_level) else $error("bad global level");

  c_ack: cover property ($fell(sda_oe_n));
  c_tristate: cover property (other_pin_oe_n == 4'hf && other_pin_own_active == 4'h0);
  c_forced: cover property (other_pin_oe_n == 4'h0 && other_pin_level == 4'hf);
endmodule : gpio_freqcount_checker

bind gpio_freqcount_status_regs gpio_freqcount_checker gpio_freqcount_checker_inst (
  .ref_clk(ref_clk), .resetn(resetn), .scl(scl), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .pin_nine_func_level(pin_nine_func_level), .pin_nine_level(pin_nine_level),
  .pin_nine_oe_n(pin_nine_oe_n), .other_pin_own_active(other_pin_own_active),
  .other_pin_func_level(other_pin_func_level), .other_pin_level(other_pin_level),
  .other_pin_oe_n(other_pin_oe_n)
);

// ### bench/i2c_ctrl_model.sv
// Purpose: two-wire controller model on the register port
// Assumes: open-drain data line with pull-up
// Notes:   hp is the scl phase length in ref_clk cycles
`timescale 1ns/100ps
module i2c_ctrl_model (
  // clock
  input  wire logic ref_clk,
  // line side
  output logic      scl,
  output logic      sda_line,
  input  wire logic sda_o,
  input  wire logic sda_oe_n
);
  logic sda_m = 1'b1;
  int   hp    = 4;
  initial scl = 1'b1;
  assign sda_line = sda_m & (sda_oe_n | sda_o);

  task automatic ph(input logic c, input logic s);
    scl <= c;
    sda_m <= s;
    repeat (hp) @(posedge ref_clk);
  endtask : ph

  task automatic start_c();
    ph(1'b0, sda_m);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask : start_c

  task automatic stop_c();
    ph(1'b0, sda_m);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask : stop_c

  // data moves one phase after scl falls, never with it
  task automatic bit_x(input logic b, output logic r);
    ph(1'b0, sda_m);
    ph(1'b0, b);
    ph(1'b1, b);
    @(negedge ref_clk);
    r = sda_line;
    @(posedge ref_clk);
  endtask : bit_x

  task automatic byte_x(input logic [7:0] d, input logic ma, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(ma, ack);
  endtask : byte_x

  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2;
    start_c();
    byte_x({a, 1'b0}, 1'b1, q, k0);
    byte_x(p, 1'b1, q, k1);
    byte_x(d, 1'b1, q, k2);
    stop_c();
    ok = ~(k0 | k1 | k2);
  endtask : write_reg

  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                          output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2, k3;
    start_c();
    byte_x({a, 1'b0}, 1'b1, q, k0);
    byte_x(p, 1'b1, q, k1);
    start_c();
    byte_x({a, 1'b1}, 1'b1, q, k2);
    byte_x(8'hff, 1'b1, d, k3);
    stop_c();
    ok = ~(k0 | k1 | k2);
  endtask : read_reg
endmodule : i2c_ctrl_model

// ### bench/tb_gpio_freqcount_status_regs.sv
// Purpose: register-level regression of the pin, count and status block
// Assumes: controller model on the serial port, pixel clock at 5 MHz
// Notes:   saturation needs more edges than a sampled pixel clock can give
`timescale 1ns/100ps
`include "gpio_freqcount_defs.svh"
module tb_gpio_freqcount_status_regs;
  logic       ref_clk, resetn, scl, sda_line, sda_o, sda_oe_n, pix_clk;
  logic       transmit_two_link_flag, receive_two_link_flag, audio_pll_locked;
  logic       serial_signal_detect, rx_lock_ch0, rx_lock_ch1, ok, lk;
  logic       pin_nine_remote_en, pin_nine_level, pin_nine_oe_n;
  logic [3:0] other_pin_own_active, other_pin_level, other_pin_oe_n, own, xoe;
  logic [7:0] d, e9;
  int         fails   = 0;
  int         n_tests = 0;

  gpio_freqcount_status_regs gpio_freqcount_status_regs_inst (
    .ref_clk(ref_clk), .resetn(resetn), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .pix_clk(pix_clk), .transmit_two_link_flag(transmit_two_link_flag),
    .receive_two_link_flag(receive_two_link_flag), .audio_pll_locked(audio_pll_locked),
    .serial_signal_detect(serial_signal_detect), .rx_lock_ch0(rx_lock_ch0),
    .rx_lock_ch1(rx_lock_ch1), .pin_nine_remote_en(pin_nine_remote_en),
    .pin_nine_remote_level(1'b0), .pin_nine_func_level(1'b0),
    .pin_nine_level(pin_nine_level), .pin_nine_oe_n(pin_nine_oe_n),
    .other_pin_own_active(other_pin_own_active), .other_pin_func_level(4'h6),
    .other_pin_level(other_pin_level), .other_pin_oe_n(other_pin_oe_n)
  );

  i2c_ctrl_model i2c_ctrl_model_inst (
    .ref_clk(ref_clk), .scl(scl), .sda_line(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
  );

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic k;
    i2c_ctrl_model_inst.write_reg(`TARGET_ADDR, p, v, k);
    chk("write ack", {7'h0, k}, 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    logic k;
    i2c_ctrl_model_inst.read_reg(`TARGET_ADDR, p, q, k);
    chk("read ack", {7'h0, k}, 8'h01);
  endtask : rd

  task automatic rd_chk(input string nm, input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    rd(p, q);
    chk(nm, q, e);
  endtask : rd_chk

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // offset keeps pixel edges away from ref_clk edges
  initial begin
    pix_clk = 1'b0;
    #7;
    forever #100 pix_clk = ~pix_clk;
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

  initial begin
    resetn = 1'b0;
    {transmit_two_link_flag, receive_two_link_flag, audio_pll_locked} = 3'h0;
    {serial_signal_detect, rx_lock_ch1, rx_lock_ch0} = 3'h0;
    pin_nine_remote_en = 1'b0;
    other_pin_own_active = 4'h0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd_chk("scratch reset", `REG_SCRATCH, 8'h01);
    rd_chk("pincfg reset", `REG_PINCFG, 8'h00);
    rd_chk("freq reset", `REG_FREQ, 8'h00);
    i2c_ctrl_model_inst.hp = 9;
    wr(`REG_SCRATCH, 8'ha5);
    rd_chk("scratch", `REG_SCRATCH, 8'ha5);
    i2c_ctrl_model_inst.hp = 4;
    i2c_ctrl_model_inst.write_reg(`TARGET_ADDR ^ 7'h01, `REG_SCRATCH, 8'h00, ok);
    chk("foreign address", {7'h0, ok}, 8'h00);
    rd_chk("scratch kept", `REG_SCRATCH, 8'ha5);
    wr(`REG_PINCFG, 8'hff);
    rd_chk("pincfg mask", `REG_PINCFG, 8'hbb);
    wr(8'h20, 8'h55);
    rd_chk("unmapped", 8'h20, 8'h00);
    for (int v = 0; v < 32; v++) begin
      own = v[4] ? 4'h5 : 4'h0;
      other_pin_own_active <= own;
      pin_nine_remote_en <= v[4];
      wr(`REG_PINCFG, {2'h2, v[3:2], 2'h2, v[1:0]});
      repeat (3) @(posedge ref_clk);
      #1;
      xoe = (v[3] ? 4'hf : 4'h0) | own;
      // own pair 00 falls back to the global pair; remote control forces an output when the enable bit is set
      e9 = (v[1:0] == 2'h0) ? {6'h0, v[3], ~v[3] & v[2]}
                            : {6'h0, v[1] & ~(v[0] & v[4]), ~v[1] & v[0] & ~v[4]};
      chk("pins oe", {4'h0, other_pin_oe_n}, {4'h0, xoe});
      chk("pins level", {4'h0, other_pin_level & ~xoe}, {4'h0, (v[2] ? 4'hf : 4'h6) & ~xoe});
      chk("pin nine", {6'h0, pin_nine_oe_n, pin_nine_level & ~pin_nine_oe_n}, e9);
      @(posedge ref_clk);
    end
    for (int i = 0; i < 64; i++) begin
      {transmit_two_link_flag, receive_two_link_flag, audio_pll_locked} <= i[5:3];
      {serial_signal_detect, rx_lock_ch1, rx_lock_ch0} <= i[2:0];
      lk = i[4] ? (i[0] & i[1]) : i[0];
      rd_chk("status", `REG_STATUS, {2'h0, i[5:3], 1'b0, i[2], lk});
    end
    wr(`REG_STATUS, 8'h00);
    rd_chk("status read only", `REG_STATUS, 8'h3b);
    i2c_ctrl_model_inst.hp = 2;
    wr(`REG_FREQ, 8'h28);
    repeat (60) @(posedge ref_clk);
    rd(`REG_FREQ, d);
    chk("freq forty", {7'h0, d >= 8'h09 && d <= 8'h0b}, 8'h01);
    wr(`REG_FREQ, 8'hff);
    wr(`REG_FREQ, 8'h14);
    repeat (40) @(posedge ref_clk);
    rd(`REG_FREQ, d);
    chk("freq restart", {7'h0, d >= 8'h04 && d <= 8'h06}, 8'h01);
    wr(`REG_FREQ, 8'h00);
    repeat (4) @(posedge ref_clk);
    rd(`REG_FREQ, d);
    chk("freq zero", d, 8'h00);
    print_verdict();
  end
endmodule : tb_gpio_freqcount_status_regs
